/* File: dv/bus_master_model.sv */
/*
 * behavioural two-wire bus master for the slave byte engine bench.
 * assumes open-drain wires resolved by the bench with pull-ups.
 */
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    // link clock
    input wire logic i_clk,
    // wire levels
    input wire logic i_scl,
    input wire logic i_sda,
    // pull-down enables
    output logic o_scl_oe,
    output logic o_sda_oe
);
    logic stalled;
    initial begin
        o_scl_oe = 1'b0;
        o_sda_oe = 1'b0;
        stalled = 1'b0;
    end
    task automatic hw();
        repeat (8) @(posedge i_clk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        int n;
        o_sda_oe <= ~b;
        hw();
        o_scl_oe <= 1'b0;
        for (n = 0; n < 4000 && i_scl !== 1'b1; n++) @(posedge i_clk);
        if (n == 4000) stalled = 1'b1;
        hw();
        r = i_sda;
        o_scl_oe <= 1'b1;
        hw();
    endtask
    task automatic send8(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    endtask
    task automatic start();
        o_sda_oe <= 1'b0;
        o_scl_oe <= 1'b0;
        hw();
        o_sda_oe <= 1'b1;
        hw();
        o_scl_oe <= 1'b1;
        hw();
    endtask
    task automatic stop();
        o_sda_oe <= 1'b1;
        hw();
        o_scl_oe <= 1'b0;
        hw();
        o_sda_oe <= 1'b0;
        hw();
    endtask
endmodule
`default_nettype wire

/* File: dv/smbus_slave_addr_match_data_reg_tb.sv */
/*
 * self-checking bench: registers, address matcher, ack and data register.
 * assumes the master model drives the far side of the wires.
 */
`timescale 1ns/1ps
`default_nettype none
module smbus_slave_addr_match_data_reg_tb;
    import smbus_addr_pkg::*;
    logic i_clk = 0, i_srst = 1, i_link_clk = 0, i_sfr_wr = 0, i_port_enable = 1;
    logic i_event_clear = 0, i_ack_value = 1, m_scl_oe, m_sda_oe, r;
    logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata, b;
    logic o_byte_event, o_ack_request, o_rx_ack, o_addressed;
    logic o_scl_out, o_scl_oe, o_sda_out, o_sda_oe;
    wire logic i_scl_in = ~(o_scl_oe | m_scl_oe);
    wire logic i_sda_in = ~(o_sda_oe | m_sda_oe);
    int n_fail = 0, checked = 0;
    // own, mask, address, acked
    logic [23:0] rows [12] = '{{16'h68FF, 7'h34, 1'b1}, {16'h68FF, 7'h35, 1'b0},
        {16'h68FF, 7'h00, 1'b0}, {16'h69FF, 7'h00, 1'b1}, {16'h68FD, 7'h35, 1'b1},
        {16'hE0E7, 7'h70, 1'b1}, {16'hE0E7, 7'h74, 1'b1}, {16'hE0E7, 7'h78, 1'b1},
        {16'hE0E7, 7'h7C, 1'b1}, {16'hE0E7, 7'h71, 1'b0}, {16'hE0E7, 7'h60, 1'b0},
        {16'hE0E7, 7'h00, 1'b0}};
    always #50 i_clk = ~i_clk;
    always #6 i_link_clk = ~i_link_clk;
    smbus_slave_addr_match_data_reg dut (.i_clk, .i_srst, .i_sfr_addr, .i_sfr_wr,
        .i_sfr_wdata, .o_sfr_rdata, .i_port_enable, .i_event_clear, .i_ack_value,
        .o_byte_event, .o_ack_request, .o_rx_ack, .o_addressed, .i_link_clk,
        .i_scl_in, .o_scl_out, .o_scl_oe, .i_sda_in, .o_sda_out, .o_sda_oe);
    bus_master_model mst (.i_clk(i_link_clk), .i_scl(i_scl_in), .i_sda(i_sda_in),
        .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_sfr_addr <= a;
        i_sfr_wdata <= d;
        i_sfr_wr <= 1'b1;
        @(posedge i_clk);
        i_sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_sfr_addr <= a;
        @(posedge i_clk);
        @(negedge i_clk);
        chk(o_sfr_rdata, exp);
    endtask
    task automatic wait_ev(input logic exp);
        for (int k = 0; k < 60 && o_byte_event !== 1'b1; k++) @(negedge i_clk);
        chk({7'h0, o_byte_event}, {7'h0, exp});
        if (o_byte_event !== exp || mst.stalled) begin
            n_fail++;
            complete_run();
        end
    endtask
    task automatic clr();
        @(posedge i_clk);
        i_event_clear <= 1'b1;
        @(posedge i_clk);
        i_event_clear <= 1'b0;
    endtask
    task automatic addr_ack(input logic [7:0] a, input logic exp);
        mst.send8(a);
        mst.bit_io(1'b1, r);
        chk({7'h0, ~r}, {7'h0, exp});
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #2_000_000;
        n_fail++;
        complete_run();
    end
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        repeat (10) @(posedge i_clk);
        i_srst <= 1'b0;
        rd(SFR_SHIFT_DATA, 8'h00);
        rd(SFR_OWN_ADDR, 8'h00);
        rd(SFR_ADDR_MASK, 8'hFE);
        rd(8'h10, 8'h00);
        // hardware ack off: host decides, even for a foreign address
        mst.start();
        mst.send8(8'h10);
        wait_ev(1'b1);
        chk({7'h0, o_ack_request}, 8'h01);
        clr();
        mst.bit_io(1'b1, r);
        chk({7'h0, ~r}, 8'h01);
        mst.stop();
        mst.start();
        mst.send8(8'hE0);
        wait_ev(1'b1);
        @(posedge i_clk) i_ack_value <= 1'b0;
        clr();
        mst.bit_io(1'b1, r);
        chk({7'h0, ~r}, 8'h00);
        addr_ack(8'h55, 1'b0);
        wait_ev(1'b0);
        mst.stop();
        @(posedge i_clk) i_ack_value <= 1'b1;
        foreach (rows[i]) begin
            wr(SFR_OWN_ADDR, rows[i][23:16]);
            wr(SFR_ADDR_MASK, rows[i][15:8]);
            rd(SFR_ADDR_MASK, rows[i][15:8]);
            mst.start();
            addr_ack({rows[i][7:1], 1'b0}, rows[i][0]);
            wait_ev(rows[i][0]);
            if (rows[i][0]) begin
                chk({7'h0, o_addressed}, 8'h01);
                rd(SFR_SHIFT_DATA, {rows[i][7:1], 1'b0});
                clr();
            end
            mst.stop();
        end
        // data bytes with hardware ack, then a preset nack
        mst.start();
        addr_ack(8'hE0, 1'b1);
        wait_ev(1'b1);
        clr();
        addr_ack(8'hA5, 1'b1);
        wait_ev(1'b1);
        chk({7'h0, o_ack_request}, 8'h00);
        rd(SFR_SHIFT_DATA, 8'hA5);
        @(posedge i_clk) i_ack_value <= 1'b0;
        clr();
        addr_ack(8'h3C, 1'b0);
        wait_ev(1'b1);
        rd(SFR_SHIFT_DATA, 8'h3C);
        clr();
        mst.stop();
        // slave transmit, tx byte loaded while the flag is set
        @(posedge i_clk) i_ack_value <= 1'b1;
        mst.start();
        addr_ack(8'hE1, 1'b1);
        wait_ev(1'b1);
        chk({7'h0, o_rx_ack}, 8'h01);
        wr(SFR_SHIFT_DATA, 8'h96);
        clr();
        for (int i = 0; i < 8; i++) begin
            mst.bit_io(1'b1, r);
            b = {b[6:0], r};
        end
        chk(b, 8'h96);
        mst.bit_io(1'b1, r);
        wait_ev(1'b1);
        chk({7'h0, o_rx_ack}, 8'h00);
        rd(SFR_SHIFT_DATA, 8'h96);
        clr();
        mst.stop();
        // port off: a matching address gets no answer
        @(posedge i_clk) i_port_enable <= 1'b0;
        mst.start();
        addr_ack(8'hE0, 1'b0);
        wait_ev(1'b0);
        mst.stop();
        @(posedge i_clk) i_port_enable <= 1'b1;
        chk({6'h0, o_scl_out, o_sda_out}, 8'h00);
        chk({7'h0, mst.stalled}, 8'h00);
        // reset in mid-run brings written registers back
        @(posedge i_clk) i_srst <= 1'b1;
        repeat (10) @(posedge i_clk);
        i_srst <= 1'b0;
        rd(SFR_ADDR_MASK, ADDR_MASK_RST);
        rd(SFR_OWN_ADDR, OWN_ADDR_RST);
        rd(SFR_SHIFT_DATA, SHIFT_DATA_RST);
        chk({7'h0, o_byte_event}, 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire

/* File: verilog/addr_matcher.sv */
/*
 * masked compare of a received address byte against the own address.
 * assumes the inputs are stable in the link clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module addr_matcher (
    // received byte and setup
    input wire logic [7:0] i_addr_byte,
    input wire logic [6:0] i_own,
    input wire logic [6:0] i_mask,
    input wire logic i_gc_enable,
    // result
    output logic o_match
);
    import smbus_addr_pkg::*;

    always_comb begin
        // low bit is direction, never compared
        o_match = (((i_addr_byte[7:1] ^ i_own) & i_mask) == 7'h00) // [R3] [R4] [R19]
            || (i_gc_enable && (i_addr_byte[7:1] == GENERAL_CALL_ADDR)); // [R5]
    end
endmodule
`default_nettype wire

/* File: verilog/bit_sync.sv */
/*
 * two flip-flop synchroniser, any width.
 * assumes each bit is a level that stays put long enough to be seen.
 */
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // levels
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    always_comb begin
        next_meta = i_srst ? '0 : i_async;
        next_sync = i_srst ? '0 : meta;
    end

    always_ff @(posedge i_clk) begin
        meta <= next_meta;
        o_sync <= next_sync;
    end
endmodule
`default_nettype wire

/* File: verilog/smbus_addr_pkg.sv */
/*
 * constants and types for the two-wire slave address matcher and data register.
 * assumes an 8-bit special-function bus addressed by byte.
 */
package smbus_addr_pkg;
    // ---------------------------------------------------------------
    // special-function addresses
    // ---------------------------------------------------------------
    localparam logic [7:0] SFR_SHIFT_DATA = 8'hC2;
    localparam logic [7:0] SFR_OWN_ADDR = 8'hF4;
    localparam logic [7:0] SFR_ADDR_MASK = 8'hF5;
    // ---------------------------------------------------------------
    // reset values and fields
    // ---------------------------------------------------------------
    localparam logic [7:0] SHIFT_DATA_RST = 8'h00;
    localparam logic [7:0] OWN_ADDR_RST = 8'h00;
    localparam logic [7:0] ADDR_MASK_RST = 8'hFE;
    localparam int GC_ENABLE_BIT = 0;
    localparam int HW_ACK_BIT = 0;
    localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] READ_EMPTY = 8'h00;
    // ---------------------------------------------------------------
    // link state machine
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_BITS,
        ST_ACK_WAIT,
        ST_ACK_DRIVE,
        ST_POST_WAIT
    } link_state_t;
endpackage

/* File: verilog/smbus_slave_addr_match_data_reg.sv */
/*
 * two-wire slave byte engine: address matcher, hardware acknowledge and the
 * shift data register, with the three special-function registers.
 * assumes the host logic owns the byte-event clear and the acknowledge value,
 * and that scl/sda are open-drain wires resolved outside.
 */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [R1] hardware ack on: match addresses and acknowledge received bytes automatically.
// [R2] hardware ack off: every acknowledge value comes from the host.
// [R3] mask bit 1: incoming address bit must equal own address bit.
// [R4] mask bit 0: that address bit is ignored, so ranges match.
// [R5] general call address accepted only when its enable bit is set.
// [R6] own 0x70, mask 0x73, no general call matches 0x70/74/78/7C.
// [R7] own address register at 0xF4: address bits 7:1, general call bit 0.
// [R8] mask register at 0xF5: mask bits 7:1, hw ack bit 0, resets 0xFE.
// [R9] data register stays unchanged while the byte-event flag is set.
// [R10] host touches data register only while the byte-event flag is set.
// [R11] bytes leave the data register most significant bit first.
// [R12] first received bit ends up in the most significant bit.
// [R13] bus level shifts in while shifting out; register holds last bus byte.
// [R14] after lost arbitration the register already holds the bus byte.
// [R15] data register: eight bits, read/write, reset zero, address 0xC2.
// [R16] device sets byte event, host clears it; clock held low meanwhile.
// [R17] host presets ack value before the byte when hardware ack is on.
// [R18] unacknowledged own address inhibits slave events until the next start.
// [R19] compare the top seven address bits; the low bit is direction.
module smbus_slave_addr_match_data_reg (
    // cpu clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // special-function bus
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    // host control
    input wire logic i_port_enable,
    input wire logic i_event_clear,
    input wire logic i_ack_value,
    // host status
    output logic o_byte_event,
    output logic o_ack_request,
    output logic o_rx_ack,
    output logic o_addressed,
    // link
    input wire logic i_link_clk,
    input wire logic i_scl_in,
    output logic o_scl_out,
    output logic o_scl_oe,
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe
);
    import smbus_addr_pkg::*;

    // ---------------------------------------------------------------
    // cpu domain registers
    // ---------------------------------------------------------------
    logic [7:0] shift_data_reg, own_slave_address, slave_address_mask;
    logic byte_event, rel_tgl, ev_seen, ack_hold, en_r, ev_tgl_s;
    logic [7:0] next_shift_data_reg, next_own_slave_address, next_slave_address_mask;
    logic next_byte_event, next_rel_tgl, next_ev_seen, next_ack_hold, next_en_r;
    logic [7:0] next_rdata;
    logic next_ack_request, next_rx_ack, next_addressed, ev_arrive;
    // link domain signals read by the cpu under handshake
    logic [7:0] shreg;
    logic ev_tgl, ev_before_ack, rx_ack, ev_addr;

    bit_sync #(.WIDTH(1)) u_ev_sync (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_async(ev_tgl),
        .o_sync(ev_tgl_s)
    );

    always_comb begin
        ev_arrive = ev_tgl_s != ev_seen;
        next_ev_seen = ev_tgl_s;
        next_en_r = i_port_enable;
        next_own_slave_address = own_slave_address;
        next_slave_address_mask = slave_address_mask;
        next_shift_data_reg = shift_data_reg;
        next_ack_request = o_ack_request;
        next_rx_ack = o_rx_ack;
        next_addressed = o_addressed;
        next_byte_event = byte_event;
        next_rel_tgl = rel_tgl;
        next_ack_hold = ack_hold;
        if (i_sfr_wr && i_sfr_addr == SFR_OWN_ADDR) begin
            next_own_slave_address = i_sfr_wdata; // [R7]
        end
        if (i_sfr_wr && i_sfr_addr == SFR_ADDR_MASK) begin
            next_slave_address_mask = i_sfr_wdata; // [R8]
        end
        if (ev_arrive) begin
            // link is stalled, its byte and status are stable
            next_shift_data_reg = shreg; // [R13] [R14]
            next_ack_request = ev_before_ack;
            next_rx_ack = rx_ack;
            next_addressed = ev_addr;
            next_byte_event = 1'b1; // [R16]
        end else begin
            if (i_sfr_wr && i_sfr_addr == SFR_SHIFT_DATA) begin
                next_shift_data_reg = i_sfr_wdata; // [R15]
            end
            if (i_event_clear && byte_event) begin
                next_byte_event = 1'b0; // [R16]
                next_rel_tgl = ~rel_tgl;
                next_ack_hold = i_ack_value;
            end
        end
        case (i_sfr_addr)
            SFR_SHIFT_DATA: next_rdata = shift_data_reg;
            SFR_OWN_ADDR: next_rdata = own_slave_address;
            SFR_ADDR_MASK: next_rdata = slave_address_mask;
            default: next_rdata = READ_EMPTY;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            shift_data_reg <= SHIFT_DATA_RST; // [R15]
            own_slave_address <= OWN_ADDR_RST; // [R7]
            slave_address_mask <= ADDR_MASK_RST; // [R8]
            byte_event <= 1'b0;
            rel_tgl <= 1'b0;
            ev_seen <= 1'b0;
            ack_hold <= 1'b0;
            en_r <= 1'b0;
            o_sfr_rdata <= READ_EMPTY;
            o_ack_request <= 1'b0;
            o_rx_ack <= 1'b0;
            o_addressed <= 1'b0;
            o_byte_event <= 1'b0;
        end else begin
            shift_data_reg <= next_shift_data_reg;
            own_slave_address <= next_own_slave_address;
            slave_address_mask <= next_slave_address_mask;
            byte_event <= next_byte_event;
            rel_tgl <= next_rel_tgl;
            ev_seen <= next_ev_seen;
            ack_hold <= next_ack_hold;
            en_r <= next_en_r;
            o_sfr_rdata <= next_rdata;
            o_ack_request <= next_ack_request && next_byte_event;
            o_rx_ack <= next_rx_ack;
            o_addressed <= next_addressed;
            o_byte_event <= next_byte_event;
        end
    end

    // ---------------------------------------------------------------
    // crossings into the link domain
    // ---------------------------------------------------------------
    logic link_rst, rel_s, match;
    logic [1:0] pin_s;
    logic [16:0] cfg_s;
    logic scl, sda, en_l, hw_ack_enable_l, gc_l;
    logic [6:0] own_l, mask_l;

    bit_sync #(.WIDTH(1)) u_rst_sync (
        .i_clk(i_link_clk),
        .i_srst(1'b0),
        .i_async(i_srst),
        .o_sync(link_rst)
    );
    bit_sync #(.WIDTH(2)) u_pin_sync (
        .i_clk(i_link_clk),
        .i_srst(1'b0),
        .i_async({i_scl_in, i_sda_in}),
        .o_sync(pin_s)
    );
    bit_sync #(.WIDTH(17)) u_cfg_sync (
        .i_clk(i_link_clk),
        .i_srst(link_rst),
        .i_async({en_r, slave_address_mask, own_slave_address}),
        .o_sync(cfg_s)
    );
    bit_sync #(.WIDTH(1)) u_rel_sync (
        .i_clk(i_link_clk),
        .i_srst(link_rst),
        .i_async(rel_tgl),
        .o_sync(rel_s)
    );

    assign scl = pin_s[1];
    assign sda = pin_s[0];
    assign en_l = cfg_s[16];
    assign mask_l = cfg_s[15:9];
    assign hw_ack_enable_l = cfg_s[8 + HW_ACK_BIT];
    assign own_l = cfg_s[7:1];
    assign gc_l = cfg_s[GC_ENABLE_BIT];

    addr_matcher u_matcher (
        .i_addr_byte(shreg),
        .i_own(own_l),
        .i_mask(mask_l),
        .i_gc_enable(gc_l),
        .o_match(match)
    );

    // ---------------------------------------------------------------
    // link byte engine
    // ---------------------------------------------------------------
    link_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [7:0] next_shreg;
    logic scl_d, sda_d, rel_seen, is_addr, tx_mode, ack_bit, inhibit;
    logic next_is_addr, next_tx_mode, next_ack_bit, next_inhibit, next_rel_seen;
    logic next_scl_oe, next_sda_oe, next_ev_tgl, next_ev_before_ack, next_rx_ack_l;
    logic next_ev_addr, start, stop, scl_rise, scl_fall, release_ev;

    always_comb begin
        start = scl_d && scl && sda_d && !sda;
        stop = scl_d && scl && !sda_d && sda;
        scl_rise = !scl_d && scl;
        scl_fall = scl_d && !scl;
        release_ev = rel_s != rel_seen;
        next_rel_seen = rel_s;
        next_state = state;
        next_cnt = cnt;
        next_shreg = shreg;
        next_is_addr = is_addr;
        next_tx_mode = tx_mode;
        next_ack_bit = ack_bit;
        next_inhibit = inhibit;
        next_scl_oe = o_scl_oe;
        next_sda_oe = o_sda_oe;
        next_ev_tgl = ev_tgl;
        next_ev_before_ack = ev_before_ack;
        next_rx_ack_l = rx_ack;
        next_ev_addr = ev_addr;
        if (!en_l) begin
            next_state = ST_IDLE;
            next_scl_oe = 1'b0;
            next_sda_oe = 1'b0;
        end else if (start) begin
            next_state = ST_BITS;
            next_cnt = 4'h0;
            next_is_addr = 1'b1;
            next_tx_mode = 1'b0;
            next_inhibit = 1'b0; // [R18]
            next_sda_oe = 1'b0;
        end else if (stop) begin
            next_state = ST_IDLE;
            next_scl_oe = 1'b0;
            next_sda_oe = 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    next_sda_oe = 1'b0;
                end
                ST_BITS: begin
                    if (scl_rise && cnt < BITS_PER_BYTE) begin
                        next_shreg = {shreg[6:0], sda}; // [R12] [R13] [R14]
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == BITS_PER_BYTE) begin
                        if (tx_mode) begin
                            next_sda_oe = 1'b0;
                            next_state = ST_ACK_DRIVE;
                        end else if (hw_ack_enable_l) begin
                            next_ack_bit = is_addr ? match : ack_hold; // [R1]
                            next_sda_oe = is_addr ? match : ack_hold; // [R1]
                            next_state = ST_ACK_DRIVE;
                        end else begin
                            next_ev_tgl = ~ev_tgl; // [R2]
                            next_ev_before_ack = 1'b1;
                            next_ev_addr = is_addr;
                            next_scl_oe = 1'b1; // [R16]
                            next_state = ST_ACK_WAIT;
                        end
                    end else if (scl_fall && tx_mode) begin
                        next_sda_oe = ~shreg[7]; // [R11]
                    end
                end
                ST_ACK_WAIT: begin
                    if (release_ev) begin
                        next_ack_bit = ack_hold; // [R2]
                        next_sda_oe = ack_hold;
                        next_scl_oe = 1'b0;
                        next_state = ST_ACK_DRIVE;
                    end
                end
                ST_ACK_DRIVE: begin
                    if (scl_rise) begin
                        next_rx_ack_l = ~sda;
                    end else if (scl_fall) begin
                        next_sda_oe = 1'b0;
                        next_is_addr = 1'b0;
                        next_cnt = 4'h0;
                        if (is_addr) begin
                            next_tx_mode = shreg[0]; // [R19]
                        end
                        if (is_addr && !ack_bit) begin
                            next_inhibit = 1'b1; // [R18]
                            next_state = ST_IDLE;
                        end else if (tx_mode || (is_addr && shreg[0]) || hw_ack_enable_l) begin
                            next_ev_tgl = ~ev_tgl; // [R1]
                            next_ev_before_ack = 1'b0;
                            next_ev_addr = is_addr;
                            next_scl_oe = 1'b1; // [R16]
                            next_state = ST_POST_WAIT;
                        end else begin
                            next_state = ST_BITS;
                        end
                    end
                end
                ST_POST_WAIT: begin
                    if (release_ev) begin
                        next_scl_oe = 1'b0;
                        if (tx_mode && !rx_ack) begin
                            next_state = ST_IDLE;
                        end else begin
                            next_state = ST_BITS;
                            if (tx_mode) begin
                                next_shreg = shift_data_reg;
                                next_sda_oe = ~shift_data_reg[7]; // [R11]
                            end
                        end
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_link_clk) begin
        if (link_rst) begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            shreg <= SHIFT_DATA_RST;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            rel_seen <= 1'b0;
            is_addr <= 1'b0;
            tx_mode <= 1'b0;
            ack_bit <= 1'b0;
            inhibit <= 1'b0;
            o_scl_oe <= 1'b0;
            o_sda_oe <= 1'b0;
            o_scl_out <= 1'b0;
            o_sda_out <= 1'b0;
            ev_tgl <= 1'b0;
            ev_before_ack <= 1'b0;
            rx_ack <= 1'b0;
            ev_addr <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            shreg <= next_shreg;
            scl_d <= scl;
            sda_d <= sda;
            rel_seen <= next_rel_seen;
            is_addr <= next_is_addr;
            tx_mode <= next_tx_mode;
            ack_bit <= next_ack_bit;
            inhibit <= next_inhibit;
            o_scl_oe <= next_scl_oe;
            o_sda_oe <= next_sda_oe;
            o_scl_out <= 1'b0;
            o_sda_out <= 1'b0;
            ev_tgl <= next_ev_tgl;
            ev_before_ack <= next_ev_before_ack;
            rx_ack <= next_rx_ack_l;
            ev_addr <= next_ev_addr;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    data_stable_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R9]
        (byte_event && !i_sfr_wr) |=> (shift_data_reg == $past(shift_data_reg)))
        else $error("data register changed while byte event set");
    reg_reset_a: assert property (@(posedge i_clk) // [R8]
        (!i_srst && $past(i_srst)) |-> (slave_address_mask == 8'hFE && own_slave_address == 8'h00))
        else $error("address registers wrong after reset");
    scl_hold_a: assert property (@(posedge i_link_clk) disable iff (link_rst) // [R16]
        (state == ST_POST_WAIT && en_l && !start && !stop && !release_ev) |=> o_scl_oe)
        else $error("clock released while event pending");
    no_self_ack_a: assert property (@(posedge i_link_clk) disable iff (link_rst) // [R2]
        (state == ST_BITS && next_state == ST_ACK_DRIVE && !tx_mode) |-> hw_ack_enable_l)
        else $error("acknowledge without host while hardware ack off");
    match_ack_a: assert property (@(posedge i_link_clk) disable iff (link_rst) // [R1]
        (state == ST_BITS && scl_fall && cnt == 4'h8 && is_addr && hw_ack_enable_l && match
            && !tx_mode && en_l && !start && !stop) |=> (state == ST_ACK_DRIVE && o_sda_oe))
        else $error("matching address not acknowledged");
    range_match_a: assert property (@(posedge i_link_clk) disable iff (link_rst) // [R6]
        (own_l == 7'h70 && mask_l == 7'h73 && !gc_l)
            |-> (match == (shreg[7:1] inside {7'h70, 7'h74, 7'h78, 7'h7C})))
        else $error("range match example failed");
    inhibit_idle_a: assert property (@(posedge i_link_clk) disable iff (link_rst) // [R18]
        (inhibit && !start) |=> (state == ST_IDLE && !o_sda_oe))
        else $error("activity while inhibited");
    msb_first_a: assert property (@(posedge i_link_clk) disable iff (link_rst) // [R11]
        (state == ST_BITS && tx_mode && scl_fall && cnt < 4'h8 && cnt > 4'h0
            && en_l && !start && !stop) |=> (o_sda_oe == ~$past(shreg[7])))
        else $error("transmit bit order wrong");
    shift_in_a: assert property (@(posedge i_link_clk) disable iff (link_rst) // [R13]
        (state == ST_BITS && scl_rise && cnt < 4'h8 && en_l && !start && !stop)
            |=> (shreg[0] == $past(sda) && shreg[7:1] == $past(shreg[6:0])))
        else $error("bus level not shifted in");
endmodule
`default_nettype wire
